// >>> core/skip_xor_exec.sv
// execution of skip, table read, exclusive-or and nibble swap operations
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module skip_xor_exec
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire skip_xor_pkg::instr_t   instr,
  input  wire logic [7:0]             mem_rdata,
  input  wire logic [skip_xor_pkg::PC_W-1:0] pc,
  input  wire logic [7:0]             table_pointer,
  input  wire logic [15:0]            prog_rdata,
  input  wire logic                   flag_write_en,
  input  wire logic [7:0]             flag_write_data,
  output logic [7:0]                  mem_raddr,
  output logic [skip_xor_pkg::PC_W-1:0] prog_addr,
  output logic                        prog_rd,
  output skip_xor_pkg::mem_write_t    mem_wr,
  output logic [7:0]                  working_register,
  output logic [7:0]                  table_high_latch,
  output logic [7:0]                  status_flags,
  output logic                        discard_prefetch,
  output logic                        busy
);
  import skip_xor_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {idle, table_wait, dummy} state_t;
  state_t state;

  instr_t held;
  logic [7:0] xor_left_right;
  logic       xor_zero;
  logic [7:0] xor_right;
  logic       mem_zero;
  logic       bit_zero;
  logic       take_skip;
  logic       start;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign start     = instr.valid && (state == idle);
  assign mem_raddr = instr.mem_addr;
  assign mem_zero  = (mem_rdata == 8'h00);
  assign bit_zero  = ~mem_rdata[instr.bit_sel];

  always_comb
  begin
    take_skip = 1'b0;
    if (start)
    begin
      case (instr.op)
        skip_if_mem_null:  take_skip = mem_zero;
        copy_skip_if_null: take_skip = mem_zero;
        skip_if_bit_null:  take_skip = bit_zero;
        default:           take_skip = 1'b0;
      endcase
    end
  end

  // immediate form uses the instruction byte, the others the memory byte
  assign xor_right = (instr.op == exor_immediate) ? instr.immediate : mem_rdata;

  xor_zero_unit u_xor
  (
    .left    (working_register),
    .right   (xor_right),
    .result  (xor_left_right),
    .is_zero (xor_zero)
  );

  // ----------------------------------------
  // table address
  // ----------------------------------------
  always_comb
  begin
    prog_rd   = 1'b0;
    prog_addr = {pc[PC_W-1:DATA_W], table_pointer};
    if (start && instr.op == table_read_current_page)
    begin
      prog_rd   = 1'b1;
      prog_addr = {pc[PC_W-1:DATA_W], table_pointer};
    end
    else if (start && instr.op == table_read_last_page)
    begin
      prog_rd   = 1'b1;
      prog_addr = {LAST_PAGE, table_pointer};
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // the dummy cycle stalls fetch; the prefetched word is dropped, not re-read
  logic   table_op;
  state_t next_state;

  assign table_op = start && (instr.op == table_read_current_page ||
                              instr.op == table_read_last_page);

  always_comb
  begin
    next_state = state;
    case (state)
      idle:
      begin
        if (take_skip)
        begin
          next_state = dummy;
        end
        else if (table_op)
        begin
          // program memory answers one cycle after the request
          next_state = table_wait;
        end
      end
      table_wait:
      begin
        next_state = idle;
      end
      dummy:
      begin
        next_state = idle;
      end
      default:
      begin
        next_state = idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= idle;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      held <= '0;
    else if (start)
      held <= instr;
  end

  assign discard_prefetch = take_skip;
  assign busy             = (state != idle);

  // ----------------------------------------
  // nibble swap
  // ----------------------------------------
  // one wire per bit; the memory byte is only read, never written back
  logic [7:0] swapped;

  genvar g;
  generate
    for (g = 0; g < DATA_W; g++)
    begin : g_swap
      assign swapped[g] = mem_rdata[(g + NIB_W) % DATA_W];
    end
  endgenerate

  // ----------------------------------------
  // working register
  // ----------------------------------------
  logic [7:0] next_working_register;

  always_comb
  begin
    next_working_register = working_register;
    if (start)
    begin
      case (instr.op)
        nibble_swap_to_working:
        begin
          next_working_register = swapped;
        end
        copy_skip_if_null:
        begin
          // loaded whether or not the skip is taken
          next_working_register = mem_rdata;
        end
        exor_to_working:
        begin
          next_working_register = xor_left_right;
        end
        exor_immediate:
        begin
          next_working_register = xor_left_right;
        end
        default:
        begin
          next_working_register = working_register;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      working_register <= WORK_RESET;
    else
      working_register <= next_working_register;
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  logic       xor_op;
  logic [7:0] next_status_flags;

  assign xor_op = start && (instr.op == exor_to_working ||
                            instr.op == exor_to_memory ||
                            instr.op == exor_immediate);

  // core writes of the status byte lose bit 0 against a same-cycle zero update
  always_comb
  begin
    next_status_flags = status_flags;
    if (flag_write_en)
    begin
      next_status_flags = flag_write_data;
    end
    if (xor_op)
    begin
      next_status_flags[ZERO_FLAG_POS] = xor_zero;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      status_flags <= FLAG_RESET;
    else
      status_flags <= next_status_flags;
  end

  // ----------------------------------------
  // memory write
  // ----------------------------------------
  mem_write_t next_mem_wr;

  always_comb
  begin
    next_mem_wr       = mem_wr;
    next_mem_wr.write = 1'b0;
    if (start && instr.op == exor_to_memory)
    begin
      next_mem_wr.write = 1'b1;
      next_mem_wr.addr  = instr.mem_addr;
      next_mem_wr.data  = xor_left_right;
    end
    else if (state == table_wait)
    begin
      // only the low half of the word lands in data memory
      next_mem_wr.write = 1'b1;
      next_mem_wr.addr  = held.mem_addr;
      next_mem_wr.data  = prog_rdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mem_wr <= '0;
    else
      mem_wr <= next_mem_wr;
  end

  // ----------------------------------------
  // table latch
  // ----------------------------------------
  logic [7:0] next_table_high_latch;

  always_comb
  begin
    next_table_high_latch = table_high_latch;
    if (state == table_wait)
    begin
      next_table_high_latch = prog_rdata[15:8];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      table_high_latch <= TABLE_RESET;
    else
      table_high_latch <= next_table_high_latch;
  end

endmodule

// >>> core/skip_xor_pkg.sv
// package: operation codes, carriers and constants of the execution block
package skip_xor_pkg;

  localparam int DATA_W    = 8;
  localparam int PROG_W    = 16;
  localparam int PC_W      = 11;
  localparam int PAGE_W    = PC_W - DATA_W;
  localparam int NIB_W     = 4;
  localparam int ZERO_FLAG_POS = 0;
  localparam logic [7:0] WORK_RESET  = 8'h00;
  localparam logic [7:0] TABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET  = 8'h00;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;
  localparam int SKIP_CYCLES   = 2;
  localparam int NOSKIP_CYCLES = 1;

  typedef enum logic [3:0] {
    op_none,
    nibble_swap_to_working,
    skip_if_mem_null,
    copy_skip_if_null,
    skip_if_bit_null,
    table_read_current_page,
    table_read_last_page,
    exor_to_working,
    exor_to_memory,
    exor_immediate
  } op_t;

  typedef struct packed {
    logic             valid;
    op_t              op;
    logic [7:0]       mem_addr;
    logic [2:0]       bit_sel;
    logic [7:0]       immediate;
  } instr_t;

  typedef struct packed {
    logic             write;
    logic [7:0]       addr;
    logic [7:0]       data;
  } mem_write_t;

endpackage

// >>> core/xor_zero_unit.sv
// xor unit: bitwise result and zero test
`timescale 1ns/1ps
module xor_zero_unit
  import skip_xor_pkg::*;
(
  input  wire logic [7:0] left,
  input  wire logic [7:0] right,
  output logic      [7:0] result,
  output logic            is_zero
);
  assign result  = left ^ right;
  assign is_zero = (result == 8'h00);
endmodule

// >>> verification/skip_xor_checker.sv
// port assertions for the execution block
`timescale 1ns/1ps
module skip_xor_checker
(
  input wire logic                     clk,
  input wire logic                     reset_n,
  input wire skip_xor_pkg::instr_t     instr,
  input wire logic [7:0]               mem_rdata,
  input wire logic [10:0]              pc,
  input wire logic [7:0]               table_pointer,
  input wire logic [15:0]              prog_rdata,
  input wire logic [10:0]              prog_addr,
  input wire logic                     prog_rd,
  input wire skip_xor_pkg::mem_write_t mem_wr,
  input wire logic [7:0]               working_register,
  input wire logic [7:0]               table_high_latch,
  input wire logic [7:0]               status_flags,
  input wire logic                     discard_prefetch,
  input wire logic                     busy
);
  import skip_xor_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire go = instr.valid && !busy;
  swap_nibbles_a: assert property (go && instr.op == nibble_swap_to_working |=>
    working_register == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
    else $error("nibble swap wrong");
  skip_null_a: assert property (go && instr.op == skip_if_mem_null |->
    discard_prefetch == (mem_rdata == 8'h00)) else $error("zero skip wrong");
  skip_dummy_a: assert property (discard_prefetch |=> busy ##1 !busy)
    else $error("dummy cycle wrong");
  copy_load_a: assert property (go && instr.op == copy_skip_if_null |=>
    working_register == $past(mem_rdata)) else $error("copy wrong");
  bit_skip_a: assert property (go && instr.op == skip_if_bit_null |->
    discard_prefetch == !mem_rdata[instr.bit_sel]) else $error("bit skip wrong");
  table_addr_a: assert property (go && instr.op inside {table_read_current_page,
    table_read_last_page} |-> prog_rd && prog_addr == {(instr.op == table_read_last_page) ?
    LAST_PAGE : pc[10:8], table_pointer}) else $error("table address wrong");
  table_store_a: assert property (prog_rd |=> ##1 mem_wr.write &&
    mem_wr.data == $past(prog_rdata[7:0]) && table_high_latch == $past(prog_rdata[15:8]))
    else $error("table store wrong");
  xor_work_a: assert property (go && instr.op == exor_to_working |=>
    working_register == ($past(working_register) ^ $past(mem_rdata)) &&
    status_flags[ZERO_FLAG_POS] == (working_register == 8'h00)) else $error("xor wrong");
  xor_mem_a: assert property (go && instr.op == exor_to_memory |=> mem_wr.write &&
    mem_wr.data == ($past(working_register) ^ $past(mem_rdata)) &&
    status_flags[ZERO_FLAG_POS] == (mem_wr.data == 8'h00)) else $error("xor store wrong");
  xor_imm_a: assert property (go && instr.op == exor_immediate |=>
    working_register == ($past(working_register) ^ $past(instr.immediate)))
    else $error("xor immediate wrong");
  skip_seen_c: cover property (discard_prefetch);
  table_seen_c: cover property (prog_rd ##2 mem_wr.write);
  xor_mem_c: cover property (go && instr.op == exor_to_memory);
endmodule

// >>> verification/mem_model.sv
// data and program memory facing the execution block
`timescale 1ns/1ps
module mem_model
(
  input  wire logic                     clk,
  input  wire logic [7:0]               mem_raddr,
  input  wire skip_xor_pkg::mem_write_t mem_wr,
  input  wire logic [10:0]              prog_addr,
  input  wire logic                     prog_rd,
  output logic [7:0]                    mem_rdata,
  output logic [15:0]                   prog_rdata
);
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
  initial prog_rdata = 16'h0000;
  assign mem_rdata = mem[mem_raddr];
  always @(posedge clk)
  begin
    if (mem_wr.write) mem[mem_wr.addr] <= mem_wr.data;
    // word flips when not fetched, so a late sample cannot match
    prog_rdata <= prog_rd ? {5'h1B, prog_addr} : ~prog_rdata;
  end
endmodule

// >>> verification/skip_xor_exec_tb_top.sv
// self-checking bench for the skip, table, xor and swap block
`timescale 1ns/1ps
module skip_xor_exec_tb_top;
  import skip_xor_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, flag_write_en = 1'b0;
  instr_t instr = '0;
  logic [10:0] pc = 11'h000;
  logic [7:0] table_pointer = 8'h00, flag_write_data = 8'h00;
  logic [7:0] mem_rdata, mem_raddr, working_register, table_high_latch, status_flags;
  logic [15:0] prog_rdata;
  logic [10:0] prog_addr;
  logic prog_rd, discard_prefetch, busy;
  mem_write_t mem_wr;
  int n_errors = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  skip_xor_exec dut_u (.*);
  mem_model mdl_u (.*);
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // issues one op; d is the expected discard, c the expected cycle count
  task automatic run(op_t o, logic [7:0] a, logic [2:0] b, logic [7:0] x, logic d, int c);
    int n;
    n = 1;
    @(posedge clk);
    instr <= '{1'b1, o, a, b, x};
    @(negedge clk);
    chk(8'(discard_prefetch), 8'(d));
    @(posedge clk);
    instr.valid <= 1'b0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 8)
    begin
      n++;
      @(negedge clk);
    end
    chk(8'(n), 8'(c));
    @(negedge clk);
  endtask
  task automatic t_xor;
    run(exor_immediate, 8'h00, 3'h0, 8'h3C, 1'b0, 1);
    chk(working_register, 8'h3C);
    chk(status_flags, 8'hFE);
    run(exor_to_working, 8'h3C, 3'h0, 8'h00, 1'b0, 1);
    chk(working_register, 8'h00);
    chk(status_flags, 8'hFF);
    run(nibble_swap_to_working, 8'h5A, 3'h0, 8'h00, 1'b0, 1);
    chk(working_register, 8'hA5);
    chk(mdl_u.mem[8'h5A] ^ status_flags, 8'hA5);
    run(exor_to_memory, 8'h0F, 3'h0, 8'h00, 1'b0, 1);
    chk(mdl_u.mem[8'h0F], 8'hAA);
    chk(working_register ^ status_flags, 8'h5B);
  endtask
  task automatic t_skip;
    run(skip_if_mem_null, 8'h00, 3'h0, 8'h00, 1'b1, SKIP_CYCLES);
    run(skip_if_mem_null, 8'h01, 3'h0, 8'h00, 1'b0, NOSKIP_CYCLES);
    run(copy_skip_if_null, 8'h00, 3'h0, 8'h00, 1'b1, SKIP_CYCLES);
    run(copy_skip_if_null, 8'h07, 3'h0, 8'h00, 1'b0, NOSKIP_CYCLES);
    chk(working_register, 8'h07);
    run(skip_if_bit_null, 8'h05, 3'h0, 8'h00, 1'b0, NOSKIP_CYCLES);
    run(skip_if_bit_null, 8'h05, 3'h1, 8'h00, 1'b1, SKIP_CYCLES);
    chk(status_flags, 8'hFE);
  endtask
  task automatic t_table;
    @(posedge clk);
    pc <= 11'h2C0;
    table_pointer <= 8'h99;
    run(table_read_current_page, 8'h20, 3'h0, 8'h00, 1'b0, 2);
    chk(mdl_u.mem[8'h20], 8'h99);
    chk(table_high_latch, {5'h1B, 3'h2});
    run(table_read_last_page, 8'h21, 3'h0, 8'h00, 1'b0, 2);
    chk(mdl_u.mem[8'h21], 8'h99);
    chk(table_high_latch, {5'h1B, LAST_PAGE});
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    flag_write_en <= 1'b1;
    flag_write_data <= 8'hFE;
    @(posedge clk);
    flag_write_en <= 1'b0;
    @(negedge clk);
    chk(working_register, WORK_RESET);
    chk(table_high_latch, TABLE_RESET);
    t_xor();
    t_skip();
    t_table();
    summarize();
  end
  // tests need about 45 cycles; this span of 700 cycles is about fifteen times that
  initial
  begin
    #35us;
    n_errors++;
    summarize();
  end
endmodule
bind skip_xor_exec skip_xor_checker chk_u (.*);
